// ==== rtl/tcso_pkg.sv ====
/*
 * Shared constants and carrier types of the transmit checksum and
 * segmentation header update block: register offsets, header field
 * positions, reset values, state codes and the stream and patch structs.
 * Assumes byte-wide streams in wire order, first byte of a word most
 * significant.
 */
package tcso_pkg;

  // Header prototype buffer size in bytes
  localparam int unsigned HDR_BYTES = 240;

  // Register offsets
  localparam logic [7:0] REG_CTL = 8'h00;
  localparam logic [7:0] REG_IPSUM = 8'h04;
  localparam logic [7:0] REG_L4SUM = 8'h08;
  localparam logic [7:0] REG_SEG = 8'h0C;
  localparam logic [7:0] REG_TOTAL_PAYLOAD_LENGTH = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // Field positions relative to the start of their own header
  localparam logic [7:0] IP4_TLEN_OFF = 8'h02;
  localparam logic [7:0] IP4_ID_OFF = 8'h04;
  localparam logic [7:0] IP6_PLEN_OFF = 8'h04;
  localparam logic [7:0] TCP_SEQ_OFF = 8'h04;
  localparam logic [7:0] TCP_FLAG_OFF = 8'h0D;
  localparam logic [7:0] UDP_LEN_OFF = 8'h04;
  localparam logic [7:0] FIN_PSH_MASK = 8'h09;

  // Reset values
  localparam logic [15:0] SUM_RST = 16'h0000;

  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOAD = 6'h02,
    ST_HDR = 6'h04,
    ST_PAY = 6'h08,
    ST_PASS = 6'h10,
    ST_PATCH = 6'h20
  } tcso_state_e;

  // Context control bits, bit 4 first
  typedef struct packed {
    logic tcp;
    logic ipv4;
    logic ip_ins;
    logic l4_sum_insert_flag;
    logic segmentation_enable;
  } tcso_flags_s;

  // One calculator's offsets
  typedef struct packed {
    logic [15:0] sum_end_offset;
    logic [7:0] insert;
    logic [7:0] sum_start_offset;
  } tcso_sumctx_s;

  // One stream byte
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tcso_byte_s;

  // Checksum write-back into a held frame
  typedef struct packed {
    logic valid;
    logic [7:0] offset;
    logic [15:0] value;
  } tcso_patch_s;

  // Whole state of the top module
  typedef struct packed {
    tcso_state_e st;
    tcso_flags_s flg;
    tcso_sumctx_s ipc;
    tcso_sumctx_s l4c;
    logic [7:0] header_length;
    logic [15:0] mss;
    logic [19:0] total_payload_length;
    logic [31:0] rdata;
    logic [7:0] hptr;
    logic [15:0] pos;
    logic [15:0] pcnt;
    logic [19:0] sent;
    logic [15:0] frames;
    logic [15:0] id;
    logic [31:0] seq;
    logic held;
    logic ov;
    tcso_byte_s ob;
    tcso_patch_s ipp;
    tcso_patch_s l4p;
  } tcso_regs_s;

  localparam tcso_regs_s REGS_RST = '{st: ST_IDLE, default: '0};

endpackage

// ==== rtl/tcso_csum.sv ====
/*
 * One's complement summing engine for one checksum field.
 * Assumes bytes arrive in wire order with their position in the frame,
 * and that clear never comes in a cycle that carries a byte.
 */
`timescale 1ns/1ns

module tcso_csum (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Frame control
  input wire logic clear,
  input wire logic [15:0] init,
  input wire tcso_pkg::tcso_sumctx_s ctx,
  // Byte stream
  input wire logic byte_en,
  input wire logic [15:0] pos,
  input wire logic [7:0] data,
  // Running sum
  output logic [15:0] sum_q
);
  import tcso_pkg::*;

  logic [15:0] sum_d;
  logic [15:0] rel;
  logic in_range;
  logic [16:0] raw;

  ////////////////////////////////////////////////////////////////////////////
  // Pair bytes into words from the start offset and fold the carry back
  always_comb begin
    rel = pos - {8'h00, ctx.sum_start_offset};
    in_range = (pos >= {8'h00, ctx.sum_start_offset}) &&
               ((ctx.sum_end_offset == 16'h0000) || (pos <= ctx.sum_end_offset));
    raw = {1'b0, sum_q} + (rel[0] ? {9'h0, data} : {1'b0, data, 8'h00});
    sum_d = sum_q;
    if (clear) begin
      sum_d = init;
    end else if (byte_en && in_range) begin
      sum_d = raw[15:0] + {15'h0, raw[16]};
    end
  end

  // Sum register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sum_q <= SUM_RST;
    end else begin
      sum_q <= sum_d;
    end
  end

endmodule

// ==== rtl/tcso_hdr_mem.sv ====
/*
 * Header prototype buffer: one write port, one read port with registered
 * read data. Assumes the reader presents next cycle's address.
 */
`timescale 1ns/1ns

module tcso_hdr_mem #(
  parameter int unsigned DEPTH = tcso_pkg::HDR_BYTES
) (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_q
);
  import tcso_pkg::*;

  logic [7:0] mem_q [DEPTH];

  // Depth must fit the byte index
  if (DEPTH < 1 || DEPTH > 256) begin : g_depth_chk
    $error("tcso_hdr_mem depth out of range");
  end

  // Writes beyond the depth are dropped, reads beyond it give zero
  always_ff @(posedge ref_clk) begin
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= (32'(rd_addr) < DEPTH) ? mem_q[rd_addr] : 8'h00;
  end

endmodule

// ==== rtl/tcso_top.sv ====
/*
 * Transmit checksum offload with segmentation header update.
 * Takes a send as a byte stream (header prototype then payload), emits
 * frames toward the MAC and writes each frame's checksums back as patches
 * into the frame held downstream. Assumes a single clock, a host that keeps
 * the context stable while a send is busy, and a MAC side that holds each
 * frame until its patches have arrived.
 */
`timescale 1ns/1ns

// How it works
// - Per frame at most one IP header checksum and one TCP or UDP checksum.
// - Sums run on the fly per frame, results written into that frame.
// - Layer-4 sum covers every payload byte plus the pseudo header.
// - Field gets complement of one's complement sum, start to end, field included.
// - Segmented frames carry optional IPv4 sum and TCP or UDP sum; never IPv6.
// - Prototype header stored once per send in the 240 byte buffer, reused.
// - Header fields rewritten as the stored prototype is replayed, before the frame's payload is fetched.
// - IPv4 total or IPv6 payload length is MSS plus header minus IP start.
// - First frame sequence number is that of its first payload byte.
// - FIN and PSH cleared in first and intermediate frames.
// - IPv4 identification increments per later frame, wrapping.
// - Later sequence number is previous plus previous payload size.
// - Last frame carries the remainder; its lengths use that remainder.
// - FIN and PSH set in the last frame when set in the prototype.
// - UDP length is MSS plus header minus layer-4 start.
// - Without segmentation only checksum fields change.
// - Context loaded with segmentation off applies until replaced.
// - Two identical, independent calculators with their own offsets.
// - Start offset counts from first byte; zero includes it, at most 255.
// - Insert offset within 256 bytes; past the frame end nothing is written.
// - Sixteen-bit end offset; zero means sum to end of frame.
// - Layer-4 sum written only when the insert flag is set.
// - Host preloads partial pseudo sum; device adds per-frame layer-4 length in segmented sends only.

module tcso_top #(
  parameter int unsigned HDR_DEPTH = tcso_pkg::HDR_BYTES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Send stream from the host side
  input wire logic in_valid,
  input wire tcso_pkg::tcso_byte_s in_byte,
  output logic in_ready,
  // Frame stream toward the MAC
  output logic out_valid,
  output tcso_pkg::tcso_byte_s out_byte,
  input wire logic out_ready,
  // Checksum write-back into the held frame
  output tcso_pkg::tcso_patch_s ip_patch,
  output tcso_pkg::tcso_patch_s l4_patch
);
  import tcso_pkg::*;

  tcso_regs_s st_q;
  tcso_regs_s st_d;
  logic [19:0] rem;
  logic last_fr;
  logic [15:0] pay;
  logic [15:0] ip_len;
  logic [15:0] l4_len;
  logic [15:0] l4_init;
  logic can_out;
  logic take;
  logic busy;
  logic csum_clr;
  logic mem_we;
  logic [7:0] src;
  logic [7:0] mem_rdata;
  logic [15:0] ip_sum;
  logic [15:0] l4_sum;

  // Buffer must hold a header and fit the byte index
  if (HDR_DEPTH < 1 || HDR_DEPTH > 256) begin : g_depth_chk
    $error("tcso_top header depth out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode helpers

  // Byte i is byte k of a header starting at base
  function automatic logic hit(input logic [7:0] i, input logic [7:0] base, input logic [7:0] k);
    return i == 8'(base + k);
  endfunction

  // A two-byte field at ins lies inside a frame of len bytes
  function automatic logic fits(input logic [7:0] ins, input logic [15:0] len);
    return ({8'h00, ins} + 16'h0002) <= len;
  endfunction

  // Rewrite one prototype byte for the current frame
  function automatic logic [7:0] hdr_byte(input logic [7:0] i, input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (st_q.flg.ipv4) begin
      if (hit(i, st_q.ipc.sum_start_offset, IP4_TLEN_OFF)) r = ip_len[15:8];
      if (hit(i, st_q.ipc.sum_start_offset, IP4_TLEN_OFF + 8'h01)) r = ip_len[7:0];
      if (hit(i, st_q.ipc.sum_start_offset, IP4_ID_OFF)) r = st_q.id[15:8];
      if (hit(i, st_q.ipc.sum_start_offset, IP4_ID_OFF + 8'h01)) r = st_q.id[7:0];
    end else begin
      if (hit(i, st_q.ipc.sum_start_offset, IP6_PLEN_OFF)) r = ip_len[15:8];
      if (hit(i, st_q.ipc.sum_start_offset, IP6_PLEN_OFF + 8'h01)) r = ip_len[7:0];
    end
    if (st_q.flg.tcp) begin
      for (int k = 0; k < 4; k++) begin
        if (hit(i, st_q.l4c.sum_start_offset, TCP_SEQ_OFF + 8'(k))) r = st_q.seq[31 - 8 * k -: 8];
      end
      // Flags keep FIN and PSH only in the last frame
      if (hit(i, st_q.l4c.sum_start_offset, TCP_FLAG_OFF) && !last_fr) r = b & ~FIN_PSH_MASK;
    end else begin
      if (hit(i, st_q.l4c.sum_start_offset, UDP_LEN_OFF)) r = l4_len[15:8];
      if (hit(i, st_q.l4c.sum_start_offset, UDP_LEN_OFF + 8'h01)) r = l4_len[7:0];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame sizes, from the bytes already sent

  always_comb begin
    rem = st_q.total_payload_length - st_q.sent;
    last_fr = rem <= {4'h0, st_q.mss};
    pay = last_fr ? rem[15:0] : st_q.mss;
    ip_len = pay + {8'h00, st_q.header_length} - {8'h00, st_q.ipc.sum_start_offset};
    l4_len = pay + {8'h00, st_q.header_length} - {8'h00, st_q.l4c.sum_start_offset};
    l4_init = st_q.flg.segmentation_enable ? l4_len : 16'h0000;
    can_out = !st_q.ov || out_ready;
    busy = st_q.st != ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register port, sequencer and output register

  always_comb begin
    st_d = st_q;
    st_d.ipp.valid = 1'b0;
    st_d.l4p.valid = 1'b0;
    st_d.rdata = 32'h0000_0000;
    in_ready = 1'b0;
    take = 1'b0;
    src = in_byte.data;
    mem_we = 1'b0;
    csum_clr = 1'b0;
    if (out_ready) begin
      st_d.ov = 1'b0;
    end

    // Register writes; the context stays until software rewrites it
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTL: st_d.flg = reg_wdata[4:0];
        REG_IPSUM: st_d.ipc = reg_wdata;
        REG_L4SUM: st_d.l4c = reg_wdata;
        REG_SEG: begin
          st_d.header_length = reg_wdata[7:0];
          st_d.mss = reg_wdata[31:16];
        end
        REG_TOTAL_PAYLOAD_LENGTH: st_d.total_payload_length = reg_wdata[19:0];
        default: ;
      endcase
    end

    // Register reads, data valid for one cycle
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTL: st_d.rdata = {{27{1'b0}}, st_q.flg};
        REG_IPSUM: st_d.rdata = st_q.ipc;
        REG_L4SUM: st_d.rdata = st_q.l4c;
        REG_SEG: st_d.rdata = {st_q.mss, 8'h00, st_q.header_length};
        REG_TOTAL_PAYLOAD_LENGTH: st_d.rdata = {12'h000, st_q.total_payload_length};
        REG_STATUS: st_d.rdata = {{14{1'b0}}, st_q.held, busy, st_q.frames};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    unique case (st_q.st)
      // Wait for a send; the mode comes from the standing context
      ST_IDLE: begin
        csum_clr = 1'b1;
        st_d.pos = 16'h0000;
        st_d.hptr = 8'h00;
        st_d.pcnt = 16'h0000;
        st_d.sent = 20'h00000;
        if (in_valid) begin
          st_d.st = st_q.flg.segmentation_enable ? ST_LOAD : ST_PASS;
        end
      end

      // Store the prototype once and catch identification and sequence
      ST_LOAD: begin
        csum_clr = 1'b1;
        in_ready = 1'b1;
        if (in_valid) begin
          mem_we = 1'b1;
          if (st_q.flg.ipv4 && hit(st_q.hptr, st_q.ipc.sum_start_offset, IP4_ID_OFF)) begin
            st_d.id[15:8] = in_byte.data;
          end
          if (st_q.flg.ipv4 && hit(st_q.hptr, st_q.ipc.sum_start_offset, IP4_ID_OFF + 8'h01)) begin
            st_d.id[7:0] = in_byte.data;
          end
          for (int k = 0; k < 4; k++) begin
            if (st_q.flg.tcp && hit(st_q.hptr, st_q.l4c.sum_start_offset, TCP_SEQ_OFF + 8'(k))) begin
              st_d.seq[31 - 8 * k -: 8] = in_byte.data;
            end
          end
          st_d.hptr = st_q.hptr + 8'h01;
          if (st_q.hptr == st_q.header_length - 8'h01) begin
            st_d.hptr = 8'h00;
            st_d.held = 1'b1;
            st_d.st = ST_HDR;
          end
        end
      end

      // Replay the stored prototype with this frame's fields
      ST_HDR: begin
        src = hdr_byte(st_q.hptr, mem_rdata);
        if (can_out) begin
          take = 1'b1;
          st_d.ob = {src, 1'b0};
          st_d.hptr = st_q.hptr + 8'h01;
          if (st_q.hptr == st_q.header_length - 8'h01) begin
            st_d.pcnt = 16'h0000;
            st_d.st = ST_PAY;
          end
        end
      end

      // Payload of one frame, MSS bytes or the remainder
      ST_PAY: begin
        in_ready = can_out;
        if (in_valid && can_out) begin
          take = 1'b1;
          st_d.ob = {in_byte.data, st_q.pcnt == pay - 16'h0001};
          st_d.pcnt = st_q.pcnt + 16'h0001;
          if (st_q.pcnt == pay - 16'h0001) begin
            st_d.sent = st_q.sent + {4'h0, pay};
            st_d.seq = st_q.seq + {16'h0000, pay};
            st_d.id = st_q.id + 16'h0001;
            st_d.frames = st_q.frames + 16'h0001;
            st_d.st = ST_PATCH;
          end
        end
      end

      // Unsegmented frame, bytes pass unchanged
      ST_PASS: begin
        in_ready = can_out;
        if (in_valid && can_out) begin
          take = 1'b1;
          st_d.ob = in_byte;
          if (in_byte.last) begin
            st_d.frames = st_q.frames + 16'h0001;
            st_d.st = ST_PATCH;
          end
        end
      end

      // Once the last byte has left, write back each enabled sum whose field fits the frame
      ST_PATCH: begin
        if (!st_q.ov) begin
          csum_clr = 1'b1;
          st_d.ipp.valid = st_q.flg.ipv4 && st_q.flg.ip_ins && fits(st_q.ipc.insert, st_q.pos);
          st_d.ipp.offset = st_q.ipc.insert;
          st_d.ipp.value = ~ip_sum;
          st_d.l4p.valid = st_q.flg.l4_sum_insert_flag && fits(st_q.l4c.insert, st_q.pos);
          st_d.l4p.offset = st_q.l4c.insert;
          st_d.l4p.value = ~l4_sum;
          st_d.pos = 16'h0000;
          st_d.hptr = 8'h00;
          st_d.pcnt = 16'h0000;
          if (st_q.flg.segmentation_enable && (st_q.sent < st_q.total_payload_length)) begin
            st_d.st = ST_HDR;
          end else begin
            st_d.st = ST_IDLE;
          end
        end
      end
    endcase

    // Accepted byte fills the output register and advances the frame
    if (take) begin
      st_d.ov = 1'b1;
      st_d.pos = st_q.pos + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= REGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state
  assign reg_rdata = st_q.rdata;
  assign out_valid = st_q.ov;
  assign out_byte = st_q.ob;
  assign ip_patch = st_q.ipp;
  assign l4_patch = st_q.l4p;

  ////////////////////////////////////////////////////////////////////////////
  // Prototype buffer and the two calculators

  // Read address is next cycle's index so data meets the header state
  tcso_hdr_mem #(
    .DEPTH(HDR_DEPTH)
  ) u_hdr_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(st_q.hptr),
    .wr_data(in_byte.data),
    .rd_addr(st_d.hptr),
    .rd_data_q(mem_rdata)
  );

  // IP header sum
  tcso_csum u_ip_sum (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(csum_clr),
    .init(16'h0000),
    .ctx(st_q.ipc),
    .byte_en(take),
    .pos(st_q.pos),
    .data(src),
    .sum_q(ip_sum)
  );

  // Layer-4 sum, seeded with the frame's length word when segmenting, else zero
  tcso_csum u_l4_sum (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(csum_clr),
    .init(l4_init),
    .ctx(st_q.l4c),
    .byte_en(take),
    .pos(st_q.pos),
    .data(src),
    .sum_q(l4_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_one_ip_sum;
    @(posedge ref_clk) disable iff (reset)
    ip_patch.valid |=> !ip_patch.valid [*2];
  endproperty
  a_one_ip_sum: assert property (p_one_ip_sum) else $error("IP sum written twice for one frame");

  property p_ip_value;
    @(posedge ref_clk) disable iff (reset)
    ip_patch.valid |-> ip_patch.value == ~$past(ip_sum);
  endproperty
  a_ip_value: assert property (p_ip_value) else $error("IP sum not the complement of the sum");

  property p_ip_v4_only;
    @(posedge ref_clk) disable iff (reset)
    ip_patch.valid |-> st_q.flg.ipv4 && st_q.flg.ip_ins;
  endproperty
  a_ip_v4_only: assert property (p_ip_v4_only) else $error("IP sum written for a non IPv4 header");

  property p_load_ready;
    @(posedge ref_clk) disable iff (reset)
    (st_q.st == ST_LOAD) |-> in_ready;
  endproperty
  a_load_ready: assert property (p_load_ready) else $error("prototype load stalled");

  property p_len_hi;
    @(posedge ref_clk) disable iff (reset)
    (st_q.st == ST_HDR && can_out && st_q.flg.ipv4 && hit(st_q.hptr, st_q.ipc.sum_start_offset, IP4_TLEN_OFF))
      |=> out_byte.data == 8'($past(ip_len) >> 8);
  endproperty
  a_len_hi: assert property (p_len_hi) else $error("IP total length high byte wrong");

  property p_fin_clear;
    @(posedge ref_clk) disable iff (reset)
    (st_q.st == ST_HDR && can_out && st_q.flg.tcp && !last_fr &&
     hit(st_q.hptr, st_q.l4c.sum_start_offset, TCP_FLAG_OFF)) |=> (out_byte.data & FIN_PSH_MASK) == 8'h00;
  endproperty
  a_fin_clear: assert property (p_fin_clear) else $error("FIN or PSH left set before last frame");

  property p_seq_id_step;
    @(posedge ref_clk) disable iff (reset)
    (st_q.st == ST_PAY && st_d.st == ST_PATCH) |=>
      (st_q.id == $past(st_q.id) + 16'h0001) && (st_q.seq == $past(st_q.seq) + {16'h0000, $past(pay)});
  endproperty
  a_seq_id_step: assert property (p_seq_id_step) else $error("identification or sequence step wrong");

  property p_pass_copy;
    @(posedge ref_clk) disable iff (reset)
    (st_q.st == ST_PASS && in_valid && in_ready) |=> out_valid && (out_byte == $past(in_byte));
  endproperty
  a_pass_copy: assert property (p_pass_copy) else $error("unsegmented byte altered");

  property p_l4_gate;
    @(posedge ref_clk) disable iff (reset)
    l4_patch.valid |-> st_q.flg.l4_sum_insert_flag;
  endproperty
  a_l4_gate: assert property (p_l4_gate) else $error("layer-4 sum written without insert flag");

  property p_ins_limit;
    @(posedge ref_clk) disable iff (reset)
    ip_patch.valid |-> ({8'h00, ip_patch.offset} + 16'h0002) <= $past(st_q.pos);
  endproperty
  a_ins_limit: assert property (p_ins_limit) else $error("IP sum written past frame end");

endmodule

// ==== dv/tcso_host_model.sv ====
/* Host side model: streams the bytes of each send into the block.
   Assumes the bench queues a send only after loading its context. */
`timescale 1ns/1ns
module tcso_host_model (
  // Clock, reset and pause
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic gap,
  // Send stream
  output logic in_valid,
  output tcso_pkg::tcso_byte_s in_byte,
  input wire logic in_ready
);
  import tcso_pkg::*;
  tcso_byte_s q[$];
  ////////////////////////////////////////
  // Idle at time zero
  initial begin
    in_valid = 1'b0;
    in_byte = '0;
  end
  // Hold each byte until taken; prototype pseudo sum goes out as given
  always @(posedge ref_clk) begin
    if (!reset && in_valid && in_ready) void'(q.pop_front());
    if (reset || !in_valid || in_ready) begin
      in_valid <= !reset && !gap && q.size() > 0;
      in_byte <= (!gap && q.size() > 0) ? q[0] : ~in_byte; // Idle data inverted
    end
  end
endmodule

// ==== dv/tx_checksum_segment_header_update_tb.sv ====
/* Bench: random plain and segmented sends, compared byte by byte and
   patch by patch with a bench model. Assumes tcso_host_model. */
`timescale 1ns/1ns
module tx_checksum_segment_header_update_tb;
  import tcso_pkg::*;
  logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, out_ready = 0, gap = 0;
  logic in_valid, in_ready, out_valid;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rd;
  tcso_byte_s in_byte, out_byte, ob[$];
  tcso_patch_s ip_patch, l4_patch, ip, l4, pq[$];
  logic [7:0] ef[$];
  integer seed = 32'h86AA55C6;
  int err_count = 0, n_checks = 0, nfr = 0, t;
  logic held_x = 1'b0; // Prototype held flag expected in status
  tcso_top dut_u (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
    .in_byte, .in_ready, .out_valid, .out_byte, .out_ready, .ip_patch, .l4_patch);
  tcso_host_model host_u (.ref_clk, .reset, .gap, .in_valid, .in_byte, .in_ready);
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  // Random stalls; log bytes and patches leaving the block
  always @(posedge ref_clk) begin
    out_ready <= $random(seed) % 4 != 0;
    gap <= $random(seed) % 8 == 0;
    if (out_valid && out_ready) ob.push_back(out_byte);
    if (ip_patch.valid || l4_patch.valid) pq.push_back(ip_patch);
    if (ip_patch.valid || l4_patch.valid) pq.push_back(l4_patch);
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Counts, verdict, end
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Register bus cycles
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Expected sum over ef, first byte high, odd byte padded, carries folded
  function logic [15:0] csum(int s, int e, logic [15:0] sd);
    logic [31:0] a;
    a = sd;
    if (e == 0) e = ef.size() - 1;
    for (int i = s; i <= e; i += 2) a += {ef[i], i < e ? ef[i + 1] : 8'h00};
    repeat (2) a = a[15:0] + a[31:16];
    return ~a[15:0];
  endfunction
  // One send: context first, then bytes, then each frame and its patches
  task automatic send(input bit seg, v4, tcp, l4f, input int ipi, pl, mss);
    int hl, ls, nf, p, b;
    bit ipv;
    logic [7:0] pro[$], pay[$];
    ls = v4 ? 20 : 40;
    b = ls + 4;
    hl = ls + (tcp ? 20 : 8);
    nf = seg ? (pl + mss - 1) / mss : 1;
    // An odd IP insert offset also turns the IP insert enable off
    wr(REG_CTL, {27'h0, tcp, v4, !ipi[0], l4f, seg});
    wr(REG_IPSUM, {16'h0013, 8'(ipi), 8'h00});
    wr(REG_L4SUM, {16'h0, 8'(ls + (tcp ? 16 : 6)), 8'(ls)});
    wr(REG_SEG, {16'(mss), 8'h00, 8'(hl)});
    wr(REG_TOTAL_PAYLOAD_LENGTH, pl);
    rdr(REG_SEG);
    chk("seg readback", rd, {16'(mss), 8'h00, 8'(hl)});
    for (int i = 0; i < hl + pl; i++) begin
      t = $random(seed);
      if (i < hl) pro.push_back(t[7:0]);
      else pay.push_back(t[7:0]);
      host_u.q.push_back({t[7:0], !seg && i == hl + pl - 1});
    end
    for (int k = 0; k < nf; k++) begin
      p = k < nf - 1 ? mss : pl - k * mss;
      ef = pro;
      if (seg) begin
        {ef[2 + 2 * !v4], ef[3 + 2 * !v4]} = 16'(p + hl);
        if (v4) {ef[4], ef[5]} = {pro[4], pro[5]} + 16'(k);
        if (!tcp) {ef[b], ef[b + 1]} = 16'(p + hl - ls);
        if (tcp) {ef[b], ef[b + 1], ef[b + 2], ef[b + 3]} = {pro[b], pro[b + 1], pro[b + 2], pro[b + 3]} + 32'(k * mss);
        if (tcp && k < nf - 1) ef[ls + 13] = pro[ls + 13] & 8'hF6;
      end
      for (int i = 0; i < p; i++) ef.push_back(pay[k * mss + i]);
      for (int w = 0; ob.size() < ef.size() || pq.size() < 2; w++) begin
        if (w > 9999) chk("frame wait", 0, 1);
        if (w > 9999) complete_run;
        @(posedge ref_clk);
      end
      foreach (ef[i]) chk("frame byte", ob.pop_front(), {ef[i], i == ef.size() - 1});
      ip = pq.pop_front();
      l4 = pq.pop_front();
      ipv = v4 && !ipi[0] && ipi + 2 <= ef.size();
      chk("ip valid", ip.valid, ipv);
      if (ipv) chk("ip sum", {ip.offset, ip.value}, {8'(ipi), csum(0, 19, 0)});
      chk("l4 valid", l4.valid, l4f);
      if (l4f) chk("l4 sum", {l4.offset, l4.value}, {8'(ls + (tcp ? 16 : 6)), csum(ls, 0, seg ? p + hl - ls : 0)});
      nfr++;
    end
    rdr(REG_STATUS);
    held_x = held_x | seg;
    chk("status", rd[17:0], {held_x, 1'b0, 16'(nfr)});
    $display("send done, frames %0d", nf);
  endtask
  ////////////////////////////////////////
  // Reset, register corners, plain sends, segmented sends
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rdr(8'h18);
    chk("unmapped read", rd, 0);
    wr(REG_STATUS, '1);
    send(0, 1, 1, 1, 10, 13, 0);
    send(0, 1, 0, 0, 10, 6, 0);
    send(0, 0, 1, 1, 10, 9, 0);
    send(0, 1, 0, 1, 250, 5, 0);
    for (int m = 0; m < 4; m++) send(1, m[0], m[1], 1, 10, 20, 8);
    send(1, 1, 1, 1, 10, 16, 8);
    repeat (6) begin
      t = $random(seed);
      send(1, t[0], t[1], t[2] | !t[0] | t[3], 10 + t[3], t[12:8] + 1, t[19:16] + 1);
    end
    complete_run;
  end
endmodule
